// ### hw/tof_consts.svh
/*
 * Offsets, field positions, reset values and timing figures of the
 * tap, orientation and flat configuration bank.
 * Assumes it is included by bare name from design and bench files.
 */
`ifndef TOF_CONSTS_SVH
`define TOF_CONSTS_SVH

// Register byte addresses on the serial register port.
`define TOF_ADDR_FIRST 8'h2b
`define TOF_ADDR_KNOCK 8'h2b
`define TOF_ADDR_ORIENT_MODE 8'h2c
`define TOF_ADDR_ORIENT_ANGLE 8'h2d
`define TOF_ADDR_LEVEL_ANGLE 8'h2e
`define TOF_ADDR_LEVEL_HOLD 8'h2f
`define TOF_REG_COUNT 5

// Reset values, reserved bits cleared.
`define TOF_RST_KNOCK 8'h0a
`define TOF_RST_ORIENT_MODE 8'h18
`define TOF_RST_ORIENT_ANGLE 8'h48
`define TOF_RST_LEVEL_ANGLE 8'h08
`define TOF_RST_LEVEL_HOLD 8'h11

// Writable bits; reserved bits store nothing and read as zero.
`define TOF_MASK_KNOCK 8'hdf
`define TOF_MASK_ORIENT_MODE 8'h7f
`define TOF_MASK_ORIENT_ANGLE 8'h7f
`define TOF_MASK_LEVEL_ANGLE 8'h3f
`define TOF_MASK_LEVEL_HOLD 8'h37

// Field positions.
`define TOF_KNOCK_SAMP_MSB 7
`define TOF_KNOCK_SAMP_LSB 6
`define TOF_KNOCK_TH_MSB 4
`define TOF_ORIENT_HYST_MSB 6
`define TOF_ORIENT_HYST_LSB 4
`define TOF_ORIENT_BLOCK_MSB 3
`define TOF_ORIENT_BLOCK_LSB 2
`define TOF_ORIENT_MODE_MSB 1
`define TOF_UPDOWN_EN_BIT 6
`define TOF_THETA_MSB 5
`define TOF_LEVEL_HOLD_MSB 5
`define TOF_LEVEL_HOLD_LSB 4
`define TOF_LEVEL_HY_MSB 2
`define TOF_UPDOWN_BIT 2

// Scaling: one tap or hysteresis step of 62.5 mg is 125 half-mg.
`define TOF_STEP_HALF_MG 10'd125

// Timing.
`define TOF_CLK_PERIOD_NS 5
`define TOF_MS_NS 1000000
`define TOF_ORIENT_STABLE_MS 12'd100
`define TOF_HOLD_0_MS 12'd0
`define TOF_HOLD_1_MS 12'd512
`define TOF_HOLD_2_MS 12'd1024
`define TOF_HOLD_3_MS 12'd2048

`endif

// ### hw/tof_pkg.sv
/*
 * Types shared by the configuration bank and its hold timer.
 * Assumes the constants header is compiled alongside.
 */
package tof_pkg;
	typedef logic [7:0] tof_byte_t;
	typedef logic [11:0] tof_ms_t;
	typedef enum logic [1:0] {
		TOF_TILTED = 2'b01,
		TOF_FLAT = 2'b10
	} tof_level_state_t;
endpackage

// ### hw/tof_stable_timer.sv
/*
 * Stability timer: reports whether a value has held still for a number
 * of millisecond ticks.
 * Assumes a one-cycle millisecond enable from the same clock.
 */
`timescale 1ns/100ps
module tof_stable_timer #(
	parameter int WIDTH = 3
) (
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_ms_tick,
	input wire logic [WIDTH-1:0] i_value,
	input wire tof_pkg::tof_ms_t i_hold_ms,
	output logic o_stable
);
	import tof_pkg::*;

	logic [WIDTH-1:0] last_reg;
	tof_ms_t count_reg;
	tof_ms_t count_next;
	logic changed;

	// The counter saturates so a value held for hours never wraps round.
	assign changed = (i_value != last_reg);
	assign count_next = changed ? 12'h000 :
		(i_ms_tick && count_reg != 12'hfff) ? count_reg + 12'h001 :
		count_reg;

	// A change drops the stable flag at once, whatever the old count.
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			last_reg <= '0;
			count_reg <= 12'h000;
			o_stable <= 1'b0;
		end else begin
			last_reg <= i_value;
			count_reg <= count_next;
			o_stable <= !changed && (count_next >= i_hold_ms);
		end
	end
endmodule // tof_stable_timer

// ### hw/tof_config_regs.sv
/*
 * Configuration bank for the tap, orientation and flat engines, with
 * the orientation and flat event qualification that it steers.
 * Assumes the serial interface logic and the motion engines run on
 * I_CLK and present single-cycle register strobes.
 */
// Functional notes
// - Tap sample count 2, 4, 8, 16.
// - Five-bit tap threshold, range-scaled step.
// - Orientation hysteresis step 62.5 mg fixed.
// - Block code 00 none, 01 theta or 1.5g.
// - Block code 10 adds slope over 0.2g.
// - Code 11: slope 0.4g, stable 100ms.
// - Threshold mode: symmetric, high or low asymmetric.
// - Up/down change raises interrupt only if enabled.
// - Six-bit orientation blocking angle.
// - Six-bit flat angle threshold.
// - Flat interrupt after hold 0/512/1024/2048 ms.
// - Flat change needs move beyond twice hysteresis.
// - Zero flat hysteresis disables hysteresis.
`timescale 1ns/100ps
`include "tof_consts.svh"
module tof_config_regs #(
	parameter int MS_CYCLES = `TOF_MS_NS / `TOF_CLK_PERIOD_NS
) (
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	input wire logic i_WR_EN,
	input wire logic i_RD_EN,
	input wire tof_pkg::tof_byte_t i_ADDR,
	input wire tof_pkg::tof_byte_t i_WDATA,
	input wire logic [1:0] i_G_RANGE,
	input wire logic [2:0] i_ORIENT,
	input wire logic i_THETA_BLOCKED,
	input wire logic i_SLOPE_OVER_LOW,
	input wire logic i_SLOPE_OVER_HIGH,
	input wire logic i_ACC_OVER_LIMIT,
	input wire logic [5:0] i_TILT,
	output tof_pkg::tof_byte_t o_RDATA,
	output logic o_RDATA_VALID,
	output logic [4:0] o_TAP_SAMPLES,
	output logic [15:0] o_KNOCK_THRESHOLD_HALF_MG,
	output logic [9:0] o_ORIENT_HYST_HALF_MG,
	output logic o_ORIENT_SYMMETRIC,
	output logic o_ORIENT_HIGH_ASYM,
	output logic o_ORIENT_LOW_ASYM,
	output logic [5:0] o_ORIENT_THETA,
	output logic [5:0] o_LEVEL_THETA,
	output logic o_ORIENT_BLOCKED,
	output logic o_ORIENT_IRQ,
	output logic o_LEVEL_FLAT,
	output logic o_LEVEL_IRQ
);
	import tof_pkg::*;

	localparam int TICK_W = $clog2(MS_CYCLES + 1);

	// Register index of an address, out of range when unmapped.
	function automatic logic [2:0] reg_index(input tof_byte_t addr);
		tof_byte_t off;
		off = addr - `TOF_ADDR_FIRST;
		reg_index = (addr >= `TOF_ADDR_FIRST &&
			off < 8'(`TOF_REG_COUNT)) ? off[2:0] : 3'h7;
	endfunction

	// Reset value of each register, reserved bits zero.
	function automatic tof_byte_t reg_reset(input int idx);
		case (idx)
			0: reg_reset = `TOF_RST_KNOCK;
			1: reg_reset = `TOF_RST_ORIENT_MODE;
			2: reg_reset = `TOF_RST_ORIENT_ANGLE;
			3: reg_reset = `TOF_RST_LEVEL_ANGLE;
			default: reg_reset = `TOF_RST_LEVEL_HOLD;
		endcase
	endfunction

	// Writable bits of each register.
	function automatic tof_byte_t reg_mask(input int idx);
		case (idx)
			0: reg_mask = `TOF_MASK_KNOCK;
			1: reg_mask = `TOF_MASK_ORIENT_MODE;
			2: reg_mask = `TOF_MASK_ORIENT_ANGLE;
			3: reg_mask = `TOF_MASK_LEVEL_ANGLE;
			default: reg_mask = `TOF_MASK_LEVEL_HOLD;
		endcase
	endfunction

	tof_byte_t cfg_reg [`TOF_REG_COUNT];
	logic [2:0] wr_index;
	logic [2:0] rd_index;
	tof_byte_t rd_word;

	assign wr_index = reg_index(i_ADDR);
	assign rd_index = rd_index_sel(i_ADDR);

	// Alias kept separate so the read path reads as its own decode.
	function automatic logic [2:0] rd_index_sel(input tof_byte_t addr);
		rd_index_sel = reg_index(addr);
	endfunction

	// One storage register per address; writes to unmapped addresses and
	// to reserved bits are dropped without any answer.
	genvar gi;
	generate
		for (gi = 0; gi < `TOF_REG_COUNT; gi++) begin : g_cfg
			always_ff @(posedge I_CLK) begin
				if (I_SYS_RST) begin
					cfg_reg[gi] <= reg_reset(gi);
				end else if (i_WR_EN && wr_index == 3'(gi)) begin
					cfg_reg[gi] <= i_WDATA & reg_mask(gi);
				end
			end
		end
	endgenerate

	// Unmapped reads return zero.
	assign rd_word = (rd_index < 3'(`TOF_REG_COUNT)) ?
		cfg_reg[rd_index] : 8'h00;

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			o_RDATA <= 8'h00;
			o_RDATA_VALID <= 1'b0;
		end else begin
			o_RDATA_VALID <= i_RD_EN;
			if (i_RD_EN) begin
				o_RDATA <= rd_word;
			end
		end
	end

	// Field extraction.
	logic [1:0] knock_samp;
	logic [4:0] knock_threshold;
	logic [2:0] orient_hyst;
	logic [1:0] orient_block;
	logic [1:0] orient_mode;
	logic updown_change_irq_enable;
	logic [5:0] orient_theta;
	logic [5:0] level_theta;
	logic [1:0] level_hold;
	logic [2:0] level_hysteresis;

	assign knock_samp = cfg_reg[0][`TOF_KNOCK_SAMP_MSB:`TOF_KNOCK_SAMP_LSB];
	assign knock_threshold = cfg_reg[0][`TOF_KNOCK_TH_MSB:0];
	assign orient_hyst =
		cfg_reg[1][`TOF_ORIENT_HYST_MSB:`TOF_ORIENT_HYST_LSB];
	assign orient_block =
		cfg_reg[1][`TOF_ORIENT_BLOCK_MSB:`TOF_ORIENT_BLOCK_LSB];
	assign orient_mode = cfg_reg[1][`TOF_ORIENT_MODE_MSB:0];
	assign updown_change_irq_enable = cfg_reg[2][`TOF_UPDOWN_EN_BIT];
	assign orient_theta = cfg_reg[2][`TOF_THETA_MSB:0];
	assign level_theta = cfg_reg[3][`TOF_THETA_MSB:0];
	assign level_hold =
		cfg_reg[4][`TOF_LEVEL_HOLD_MSB:`TOF_LEVEL_HOLD_LSB];
	assign level_hysteresis = cfg_reg[4][`TOF_LEVEL_HY_MSB:0];

	// Scaled settings in half-mg; the range input is applied live, so a
	// range change takes effect the next cycle without a register write.
	logic [4:0] tap_samples_next;
	logic [15:0] knock_half_mg_base;
	logic [15:0] knock_half_mg_next;
	logic [9:0] orient_hyst_next;

	assign tap_samples_next = 5'h02 << knock_samp;
	assign knock_half_mg_base = 16'(knock_threshold) *
		16'(`TOF_STEP_HALF_MG);
	assign knock_half_mg_next = knock_half_mg_base << i_G_RANGE;
	assign orient_hyst_next = 10'(orient_hyst) * `TOF_STEP_HALF_MG;

	// Millisecond enable shared by both stability timers.
	logic [TICK_W-1:0] tick_count_reg;
	logic ms_tick;

	assign ms_tick = (tick_count_reg == TICK_W'(MS_CYCLES - 1));

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			tick_count_reg <= '0;
		end else begin
			tick_count_reg <= ms_tick ? '0 : tick_count_reg + 1'b1;
		end
	end

	// Orientation blocking; code 11 also waits for 100 ms of stillness.
	logic orient_stable;
	logic orient_blocked_next;

	tof_stable_timer #(
		.WIDTH(3)
	) u_orient_timer (
		.i_clk(I_CLK),
		.i_sys_rst(I_SYS_RST),
		.i_ms_tick(ms_tick),
		.i_value(i_ORIENT),
		.i_hold_ms(`TOF_ORIENT_STABLE_MS),
		.o_stable(orient_stable)
	);

	assign orient_blocked_next =
		(orient_block == 2'b00) ? 1'b0 :
		(orient_block == 2'b01) ?
			(i_THETA_BLOCKED || i_ACC_OVER_LIMIT) :
		(orient_block == 2'b10) ?
			(i_THETA_BLOCKED || i_SLOPE_OVER_LOW ||
			i_ACC_OVER_LIMIT) :
			(i_THETA_BLOCKED || i_SLOPE_OVER_HIGH ||
			i_ACC_OVER_LIMIT || !orient_stable);

	// A masked orientation change waits while blocked; a new change in
	// the cycle that fires the old one keeps the event pending. The raw
	// value is tracked and only the compare is masked, so toggling the
	// up/down enable can never fake a change by itself.
	logic [2:0] orient_watch;
	logic [2:0] orient_last_reg;
	logic orient_pending_reg;
	logic orient_change;
	logic orient_fire;

	assign orient_watch = updown_change_irq_enable ? 3'h7 :
		~(3'h1 << `TOF_UPDOWN_BIT);
	assign orient_change =
		(((i_ORIENT ^ orient_last_reg) & orient_watch) != 3'h0);
	assign orient_fire = orient_pending_reg && !orient_blocked_next;

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			orient_last_reg <= 3'h0;
			orient_pending_reg <= 1'b0;
		end else begin
			orient_last_reg <= i_ORIENT;
			orient_pending_reg <= orient_change ||
				(orient_pending_reg && !orient_fire);
		end
	end

	// Flat state with hysteresis band of twice the setting; a zero setting
	// leaves a plain compare against the angle threshold.
	tof_level_state_t level_state_reg;
	tof_level_state_t level_state_next;
	logic [7:0] level_band;
	logic [7:0] tilt_wide;
	logic [7:0] theta_wide;

	assign level_band = 8'({level_hysteresis, 1'b0});
	assign tilt_wide = 8'(i_TILT);
	assign theta_wide = 8'(level_theta);

	always_comb begin
		level_state_next = level_state_reg;
		case (level_state_reg)
			TOF_TILTED: begin
				if (tilt_wide + level_band < theta_wide) begin
					level_state_next = TOF_FLAT;
				end
			end
			TOF_FLAT: begin
				if (tilt_wide > theta_wide + level_band) begin
					level_state_next = TOF_TILTED;
				end
			end
			default: level_state_next = TOF_TILTED;
		endcase
	end

	// Hold time decode, selected by the two-bit field.
	tof_ms_t level_hold_ms;
	logic level_stable;
	logic level_pending_reg;
	logic level_fire;

	assign level_hold_ms = (level_hold == 2'b00) ? `TOF_HOLD_0_MS :
		(level_hold == 2'b01) ? `TOF_HOLD_1_MS :
		(level_hold == 2'b10) ? `TOF_HOLD_2_MS : `TOF_HOLD_3_MS;

	tof_stable_timer #(
		.WIDTH(2)
	) u_level_timer (
		.i_clk(I_CLK),
		.i_sys_rst(I_SYS_RST),
		.i_ms_tick(ms_tick),
		.i_value(level_state_next),
		.i_hold_ms(level_hold_ms),
		.o_stable(level_stable)
	);

	assign level_fire = level_pending_reg && level_stable;

	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			level_state_reg <= TOF_TILTED;
			level_pending_reg <= 1'b0;
		end else begin
			level_state_reg <= level_state_next;
			level_pending_reg <= (level_state_next != level_state_reg) ||
				(level_pending_reg && !level_fire);
		end
	end

	// Registered outputs toward the motion engines.
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST) begin
			o_TAP_SAMPLES <= 5'h02;
			o_KNOCK_THRESHOLD_HALF_MG <= 16'h0000;
			o_ORIENT_HYST_HALF_MG <= 10'h000;
			o_ORIENT_SYMMETRIC <= 1'b1;
			o_ORIENT_HIGH_ASYM <= 1'b0;
			o_ORIENT_LOW_ASYM <= 1'b0;
			o_ORIENT_THETA <= 6'h00;
			o_LEVEL_THETA <= 6'h00;
			o_ORIENT_BLOCKED <= 1'b0;
			o_ORIENT_IRQ <= 1'b0;
			o_LEVEL_FLAT <= 1'b0;
			o_LEVEL_IRQ <= 1'b0;
		end else begin
			o_TAP_SAMPLES <= tap_samples_next;
			o_KNOCK_THRESHOLD_HALF_MG <= knock_half_mg_next;
			o_ORIENT_HYST_HALF_MG <= orient_hyst_next;
			o_ORIENT_SYMMETRIC <= (orient_mode[0] == orient_mode[1]);
			o_ORIENT_HIGH_ASYM <= (orient_mode == 2'b01);
			o_ORIENT_LOW_ASYM <= (orient_mode == 2'b10);
			o_ORIENT_THETA <= orient_theta;
			o_LEVEL_THETA <= level_theta;
			o_ORIENT_BLOCKED <= orient_blocked_next;
			o_ORIENT_IRQ <= orient_fire;
			o_LEVEL_FLAT <= (level_state_reg == TOF_FLAT);
			o_LEVEL_IRQ <= level_fire;
		end
	end
endmodule // tof_config_regs

// ### tb/tof_regs_sva.sv
/* Port checker for the tap, orientation and flat bank.
   Assumes it is bound to tof_config_regs, all on I_CLK. */
`timescale 1ns/100ps
module tof_regs_sva (
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	input wire logic i_WR_EN,
	input wire logic i_RD_EN,
	input wire tof_pkg::tof_byte_t i_ADDR,
	input wire tof_pkg::tof_byte_t i_WDATA,
	input wire logic i_THETA_BLOCKED,
	input wire logic i_SLOPE_OVER_LOW,
	input wire logic i_SLOPE_OVER_HIGH,
	input wire logic i_ACC_OVER_LIMIT,
	input wire logic o_RDATA_VALID,
	input wire logic [4:0] o_TAP_SAMPLES,
	input wire logic o_ORIENT_BLOCKED,
	input wire logic o_ORIENT_IRQ,
	input wire logic o_LEVEL_IRQ
);
	import tof_pkg::*;
	logic [1:0] blk_reg;
	// Write decodes for the tap register and the blocking register that the checker shadows.
	wire logic tap_wr = i_WR_EN && i_ADDR == 8'h2b;
	wire logic blk_wr = i_WR_EN && i_ADDR == 8'h2c;
	// Shadow of the blocking code, so that the block can be predicted.
	always_ff @(posedge I_CLK) begin
		if (I_SYS_RST)
			blk_reg <= 2'h2;
		else if (blk_wr)
			blk_reg <= i_WDATA[3:2];
	end
	default clocking @(posedge I_CLK);
	endclocking
	default disable iff (I_SYS_RST);
	rd_valid_a: assert property (o_RDATA_VALID == $past(i_RD_EN))
		else $error("read valid not one cycle after strobe");
	tap_samp_a: assert property (tap_wr ##1 !tap_wr [*2] |=>
		o_TAP_SAMPLES == 5'd2 << ($past(i_WDATA, 3) >> 6))
		else $error("tap sample count wrong");
	blk_none_a: assert property (blk_reg == 2'h0 &&
		$stable(blk_reg) && !blk_wr |=> !o_ORIENT_BLOCKED)
		else $error("blocked with blocking off");
	blk_theta_a: assert property (blk_reg != 2'h0 && !blk_wr &&
		(i_THETA_BLOCKED || i_ACC_OVER_LIMIT) |=> o_ORIENT_BLOCKED)
		else $error("theta or limit did not block");
	blk_low_a: assert property (blk_reg == 2'h2 && !blk_wr &&
		i_SLOPE_OVER_LOW |=> o_ORIENT_BLOCKED)
		else $error("low slope did not block");
	blk_high_a: assert property (blk_reg == 2'h3 && !blk_wr &&
		i_SLOPE_OVER_HIGH |=> o_ORIENT_BLOCKED)
		else $error("high slope did not block");
	irq_pulse_a: assert property (o_ORIENT_IRQ |=> !o_ORIENT_IRQ)
		else $error("orientation event longer than a cycle");
	lvl_pulse_a: assert property ($rose(o_LEVEL_IRQ) |=>
		$fell(o_LEVEL_IRQ))
		else $error("flat event longer than a cycle");
	cover property (o_ORIENT_IRQ);
	cover property (o_LEVEL_IRQ);
	cover property (blk_reg == 2'h3 && o_ORIENT_BLOCKED);
endmodule // tof_regs_sva

// ### tb/tof_config_regs_tb.sv
/* Self-checking bench for tof_config_regs: register access, decoded
   fields, orientation blocking and flat events.
   Assumes design files and checker are compiled before it. */
`timescale 1ns/100ps
`include "tof_consts.svh"
module tof_config_regs_tb;
	import tof_pkg::*;
	logic I_CLK, I_SYS_RST, i_WR_EN, i_RD_EN;
	tof_byte_t i_ADDR, i_WDATA, o_RDATA, d, exp_q[$];
	logic [1:0] i_G_RANGE;
	logic [2:0] i_ORIENT, h;
	logic i_THETA_BLOCKED, i_SLOPE_OVER_LOW, i_SLOPE_OVER_HIGH, e;
	logic i_ACC_OVER_LIMIT, o_RDATA_VALID, o_ORIENT_SYMMETRIC;
	logic [5:0] i_TILT, o_ORIENT_THETA, o_LEVEL_THETA;
	logic [4:0] o_TAP_SAMPLES;
	logic [15:0] o_KNOCK_THRESHOLD_HALF_MG;
	logic [9:0] o_ORIENT_HYST_HALF_MG;
	logic o_ORIENT_HIGH_ASYM, o_ORIENT_LOW_ASYM, o_ORIENT_BLOCKED;
	logic o_ORIENT_IRQ, o_LEVEL_FLAT, o_LEVEL_IRQ;
	int error_cnt, checks_done, i, j;
	tof_byte_t rst_v[5] = '{`TOF_RST_KNOCK, `TOF_RST_ORIENT_MODE,
		`TOF_RST_ORIENT_ANGLE, `TOF_RST_LEVEL_ANGLE, `TOF_RST_LEVEL_HOLD};
	tof_byte_t msk_v[5] = '{`TOF_MASK_KNOCK, `TOF_MASK_ORIENT_MODE,
		`TOF_MASK_ORIENT_ANGLE, `TOF_MASK_LEVEL_ANGLE, `TOF_MASK_LEVEL_HOLD};

	// Millisecond count cut to 10 cycles so hold times stay short.
	tof_config_regs #(.MS_CYCLES(10)) dut (.*);

	// 200 MHz clock.
	always #2.5 I_CLK = ~I_CLK;

	task automatic chk(input string n, input logic [15:0] ev, gv);
		checks_done++;
		if (gv !== ev) begin
			error_cnt++;
			$display("mismatch %s exp %h got %h", n, ev, gv);
		end
	endtask

	// Read answers are matched, oldest first, against noted values.
	always @(negedge I_CLK) begin
		if (o_RDATA_VALID === 1'b1)
			chk("rdata", exp_q.pop_front(), o_RDATA);
	end

	task automatic idle(input int n);
		repeat (n) @(negedge I_CLK);
	endtask

	task automatic wr_reg(input tof_byte_t a, v);
		@(negedge I_CLK);
		i_WR_EN = 1'b1;
		i_ADDR = a;
		i_WDATA = v;
		@(negedge I_CLK);
		i_WR_EN = 1'b0;
	endtask

	task automatic rd_reg(input tof_byte_t a, v);
		@(negedge I_CLK);
		i_RD_EN = 1'b1;
		i_ADDR = a;
		exp_q.push_back(v);
		@(negedge I_CLK);
		i_RD_EN = 1'b0;
	endtask

	// Watches an event output for a bounded number of cycles.
	task automatic pulse(input logic sel, input int lim, input logic ev);
		logic hit;
		hit = 1'b0;
		repeat (lim) begin
			@(negedge I_CLK);
			if ((sel ? o_LEVEL_IRQ : o_ORIENT_IRQ) === 1'b1)
				hit = 1'b1;
		end
		chk("event", ev, hit);
	endtask

	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial begin
		{I_CLK, i_WR_EN, i_RD_EN, i_ADDR, i_WDATA, i_G_RANGE} = '0;
		{i_ORIENT, i_THETA_BLOCKED, i_SLOPE_OVER_LOW} = '0;
		{i_SLOPE_OVER_HIGH, i_ACC_OVER_LIMIT} = '0;
		i_TILT = 6'h1e;
		I_SYS_RST = 1'b1;
		error_cnt = 0;
		checks_done = 0;
		void'($urandom(32'h8072379a));
		idle(16);
		I_SYS_RST = 1'b0;
		for (i = 0; i < 5; i++)
			rd_reg(8'h2b + i[7:0], rst_v[i]);
		rd_reg(8'h2a, 8'h00);
		$display("test reset values done");
		// Reserved bits must read back as zero.
		for (i = 0; i < 6; i++) begin
			d = $urandom;
			wr_reg(8'h2b + i[7:0], d);
			rd_reg(8'h2b + i[7:0], i < 5 ? d & msk_v[i] : 8'h00);
		end
		idle(2);
		$display("test read back done");
		// Every sample code, and the threshold under every live range.
		for (i = 0; i < 4; i++) begin
			d = {i[1:0], 1'b0, 5'($urandom)};
			wr_reg(8'h2b, d);
			for (j = 0; j < 4; j++) begin
				i_G_RANGE = j[1:0];
				idle(3);
				chk("knock", 16'(d[4:0] * 125 << j), o_KNOCK_THRESHOLD_HALF_MG);
			end
			chk("taps", 16'(5'd2 << i), o_TAP_SAMPLES);
		end
		$display("test tap done");
		// Each blocking code against each blocking cause in turn.
		for (i = 0; i < 4; i++) begin
			h = $urandom;
			wr_reg(8'h2c, {1'b0, h, i[1:0], i[1:0]});
			idle(3);
			chk("hyst", 16'(h * 125), o_ORIENT_HYST_HALF_MG);
			chk("mode", {i == 1, i == 2, i == 0 || i == 3}, {o_ORIENT_HIGH_ASYM, o_ORIENT_LOW_ASYM, o_ORIENT_SYMMETRIC});
			for (j = 0; j < 4; j++) begin
				{i_THETA_BLOCKED, i_SLOPE_OVER_LOW, i_SLOPE_OVER_HIGH, i_ACC_OVER_LIMIT} = 4'h8 >> j;
				idle(3);
				e = i != 0 && (j == 0 || j == 3 || j == i - 1);
				if (e || i < 3)
					chk("blocked", e, o_ORIENT_BLOCKED);
			end
			{i_THETA_BLOCKED, i_SLOPE_OVER_LOW, i_SLOPE_OVER_HIGH, i_ACC_OVER_LIMIT} = 4'h0;
		end
		$display("test orientation blocking done");
		wr_reg(8'h2c, 8'h00);
		d = $urandom;
		wr_reg(8'h2d, {2'b01, d[5:0]});
		wr_reg(8'h2e, {2'b00, d[5:0] ^ 6'h3f});
		idle(4);
		chk("otheta", d[5:0], o_ORIENT_THETA);
		chk("ltheta", d[5:0] ^ 6'h3f, o_LEVEL_THETA);
		i_ORIENT = i_ORIENT ^ 3'h4;
		pulse(1'b0, 4, 1'b1);
		// Turning the enable off must not raise an event by itself.
		wr_reg(8'h2d, {2'b00, d[5:0]});
		pulse(1'b0, 4, 1'b0);
		i_ORIENT = i_ORIENT ^ 3'h4;
		pulse(1'b0, 6, 1'b0);
		i_ORIENT = i_ORIENT ^ 3'h1;
		pulse(1'b0, 4, 1'b1);
		$display("test orientation events done");
		// Flat threshold 20, then hysteresis 2, none, and a hold time.
		wr_reg(8'h2e, 8'h14);
		wr_reg(8'h2f, 8'h00);
		idle(4);
		i_TILT = 6'h0a;
		pulse(1'b1, 6, 1'b1);
		chk("flat", 1'b1, o_LEVEL_FLAT);
		wr_reg(8'h2f, 8'h02);
		i_TILT = 6'h17;
		pulse(1'b1, 6, 1'b0);
		i_TILT = 6'h19;
		pulse(1'b1, 6, 1'b1);
		wr_reg(8'h2f, 8'h00);
		i_TILT = 6'h13;
		pulse(1'b1, 6, 1'b1);
		wr_reg(8'h2f, 8'h10);
		i_TILT = 6'h1e;
		pulse(1'b1, 4000, 1'b0);
		pulse(1'b1, 1500, 1'b1);
		chk("flat", 1'b0, o_LEVEL_FLAT);
		$display("test flat done");
		close_out();
	end
endmodule // tof_config_regs_tb

bind tof_config_regs tof_regs_sva chk_i (.*);
